// ### tb/mqps_ctrl_model.sv
`timescale 1ns/1ps
// Controller on both ports; each task is entered just after a rising edge
module mqps_ctrl_model (
    input wire logic clk_in,
    output logic wr_sel_out,
    output logic [4:0] wr_addr_out,
    output logic wr_en_n_out,
    output logic [17:0] wr_data_out,
    output logic rd_sel_out,
    output logic [5:0] rd_addr_out,
    output logic rd_en_n_out
);
    // Idle lines, no strobe or enable asserted
    initial
    begin
        wr_sel_out = 1'b0;
        wr_addr_out = 5'h00;
        wr_en_n_out = 1'b1;
        wr_data_out = 18'h00000;
        rd_sel_out = 1'b0;
        rd_addr_out = 6'h00;
        rd_en_n_out = 1'b1;
    end
    // One device at a time; a quiet edge keeps selections two cycles apart
    task automatic wr_select(input logic [4:0] a);
        wr_sel_out <= 1'b1;
        wr_addr_out <= a;
        @(posedge clk_in);
        wr_sel_out <= 1'b0;
        wr_addr_out <= ~a; // Stale address must not matter
        @(posedge clk_in);
    endtask
    // Strobe high on exactly one edge
    task automatic rd_select(input logic [5:0] a);
        rd_sel_out <= 1'b1;
        rd_addr_out <= a;
        @(posedge clk_in);
        rd_sel_out <= 1'b0;
        rd_addr_out <= ~a;
        @(posedge clk_in);
    endtask
    // Data released to its inverse once the enable has gone
    task automatic wr_word(input logic [17:0] d);
        wr_en_n_out <= 1'b0;
        wr_data_out <= d;
        @(posedge clk_in);
        wr_en_n_out <= 1'b1;
        wr_data_out <= ~d;
        @(posedge clk_in);
    endtask
    task automatic rd_pop;
        rd_en_n_out <= 1'b0;
        @(posedge clk_in);
        rd_en_n_out <= 1'b1;
        @(posedge clk_in);
    endtask
endmodule

// ### tb/mqps_top_bench.sv
`timescale 1ns/1ps
module mqps_top_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic w_sel, w_en_n, r_sel, r_en_n, ack, valid_n, full_n, full_oe;
    logic [4:0] w_addr;
    logic [5:0] r_addr;
    logic [17:0] w_data, rd_data;
    logic [31:0] wb_q;
    // Straps and lane select held as bench state, so a scenario can move them
    logic [3:0] lanes = 4'hF;
    logic in_narrow = 1'b0;
    logic out_narrow = 1'b1;
    logic [2:0] own_id = 3'h5;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    // Shared full line with its pull-up
    wire full_line = full_oe ? full_n : 1'b1;
    always #50 clk = ~clk;
    mqps_top dut_u (.REF_CLK_IN(clk), .RSTN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(lanes), .WB_DAT_IN(wdat), .WB_DAT_OUT(wb_q),
        .WB_ACK_OUT(ack), .WR_SEL_IN(w_sel), .WR_ADDR_IN(w_addr), .WR_EN_N_IN(w_en_n),
        .WR_DATA_IN(w_data), .RD_SEL_IN(r_sel), .RD_ADDR_IN(r_addr), .RD_EN_N_IN(r_en_n),
        .IN_WIDTH_SEL_IN(in_narrow), .OUT_WIDTH_SEL_IN(out_narrow), .DEVICE_ID_IN(own_id),
        .RD_DATA_OUT(rd_data), .WORD_VALID_N_OUT(valid_n), .QUEUE_FULL_N_OUT(full_n),
        .QUEUE_FULL_OE_OUT(full_oe));
    mqps_ctrl_model ctrl_u (.clk_in(clk), .wr_sel_out(w_sel), .wr_addr_out(w_addr),
        .wr_en_n_out(w_en_n), .wr_data_out(w_data), .rd_sel_out(r_sel), .rd_addr_out(r_addr),
        .rd_en_n_out(r_en_n));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle, held until ack is sampled high at a rising edge, released there
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
            miscompares++;
        q = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_valid;
        int n;
        n = 0;
        @(negedge clk);
        while (valid_n !== 1'b0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask
    task automatic t_regs;
        wb(1'b0, 4'h0, 32'h0);
        check(q, 32'h0);
        wb(1'b1, 4'h0, 32'h2);
        wb(1'b0, 4'h0, 32'h0);
        check(q, 32'h2);
        wb(1'b1, 4'h0, 32'h0);
        wb(1'b0, 4'h4, 32'h0);
        check({29'h0, q[10:8]}, 32'h6);
        wb(1'b0, 4'h8, 32'h0);
        check(q, 32'h0);
        $display("test regs done");
    endtask
    // Eight wide words fill the 16-byte queue; a ninth is dropped
    task automatic t_fill;
        ctrl_u.wr_select(5'h14);
        for (int i = 0; i < 8; i++)
        begin
            ctrl_u.wr_word({9'(2 * i + 1), 9'(2 * i)});
        end
        ctrl_u.wr_word(18'h3FFFF);
        @(negedge clk);
        check({full_oe, full_n}, 32'h2);
        $display("test fill done");
    endtask
    task automatic t_expand;
        @(posedge clk);
        ctrl_u.wr_select(5'h08);
        @(negedge clk);
        check({full_oe, full_line}, 32'h1);
        @(posedge clk);
        ctrl_u.wr_select(5'h15);
        @(negedge clk);
        check({full_oe, full_n}, 32'h3);
        @(posedge clk);
        ctrl_u.wr_select(5'h14);
        @(negedge clk);
        check({full_oe, full_line}, 32'h2);
        $display("test expand done");
    endtask
    // Bytes come out low half first; two reads free one wide unit
    task automatic t_drain;
        @(posedge clk);
        ctrl_u.rd_select(6'h28);
        for (int j = 0; j < 16; j++)
        begin
            wait_valid();
            check(rd_data, 32'(j));
            ctrl_u.rd_pop();
            @(negedge clk);
            if (j == 1)
                check(full_n, 32'h1);
        end
        check({valid_n, rd_data}, 32'h4000F);
        $display("test drain done");
    endtask
    task automatic t_null;
        @(posedge clk);
        ctrl_u.wr_select(5'h15);
        ctrl_u.wr_word({9'h1B, 9'h1A});
        ctrl_u.rd_select(6'h29);
        wait_valid();
        ctrl_u.rd_pop();
        wait_valid();
        ctrl_u.rd_select(6'h2F);
        ctrl_u.rd_pop();
        ctrl_u.wr_word({9'h1D, 9'h1C});
        repeat (6) @(posedge clk);
        @(negedge clk);
        check({valid_n, rd_data}, 32'h4001B);
        @(posedge clk);
        ctrl_u.rd_select(6'h29);
        wait_valid();
        check({valid_n, rd_data}, 32'h1C);
        $display("test null done");
    endtask
    task automatic summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Cut a hang short well past the expected run length
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_regs();
        t_fill();
        t_expand();
        t_drain();
        t_null();
        summarize();
    end
endmodule

// ### verilog/mqps_pkg.sv
package mqps_pkg;
    localparam int NUM_Q = 4;
    localparam int PTR_W = 4;
    localparam logic [4:0] Q_DEPTH = 5'h10;
    localparam logic [4:0] UNIT_NARROW = 5'h01;
    localparam logic [4:0] UNIT_WIDE = 5'h02;
    localparam logic [1:0] CFG_SETTLE = 2'h3;
    localparam logic [3:0] CTRL_OFFS = 4'h0;
    localparam logic [3:0] STATUS_OFFS = 4'h4;
    localparam int CTRL_PACKET_BIT = 0;
    localparam int CTRL_WBLOCK_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int WR_Q_LSB = 0;
    localparam int WR_DEV_LSB = 2;
    localparam int RD_NULL_BIT = 2;
    localparam int RD_DEV_LSB = 3;

    // Queue selection as held by either port
    typedef struct packed {
        logic [1:0] q;
        logic null_q;
        logic hit;
    } mqps_sel_s;

    localparam mqps_sel_s SEL_RESET = '{q: 2'h0, null_q: 1'b1, hit: 1'b0};
endpackage

// ### verilog/mqps_top.sv
`timescale 1ns/1ps
module mqps_top (
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [3:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic WR_SEL_IN,
    input wire logic [4:0] WR_ADDR_IN,
    input wire logic WR_EN_N_IN,
    input wire logic [17:0] WR_DATA_IN,
    input wire logic RD_SEL_IN,
    input wire logic [5:0] RD_ADDR_IN,
    input wire logic RD_EN_N_IN,
    input wire logic IN_WIDTH_SEL_IN,
    input wire logic OUT_WIDTH_SEL_IN,
    input wire logic [2:0] DEVICE_ID_IN,
    output logic [17:0] RD_DATA_OUT,
    output logic WORD_VALID_N_OUT,
    output logic QUEUE_FULL_N_OUT,
    output logic QUEUE_FULL_OE_OUT
);
    localparam int N = mqps_pkg::NUM_Q;

    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic [1:0] cfg_cnt_r;
    logic cfg_done_r;
    logic narrow_in_r;
    logic narrow_out_r;
    logic [1:0] ctrl_r;
    logic wb_ack_r;
    logic [31:0] wb_dat_r;
    mqps_pkg::mqps_sel_s wsel_r;
    mqps_pkg::mqps_sel_s wact_r;
    mqps_pkg::mqps_sel_s rsel_r;
    mqps_pkg::mqps_sel_s rsrc_r;
    logic full_n_r;
    logic full_oe_r;
    logic [17:0] st_data_r;
    logic st_v_r;
    logic [17:0] out_data_r;
    logic out_v_r;
    logic [8:0] mem [0:N*16-1];
    logic [4:0] cnt_r [0:N-1];
    logic [4:0] cnt_nxt [0:N-1];
    logic [3:0] wp_w [0:N-1];
    logic [3:0] rp_w [0:N-1];
    logic [N-1:0] q_full;
    logic [N-1:0] q_ready;

    // Static pins pass two flops before anything reads them
    wire logic [2:0] dev_id = pin_s2_r[2:0];
    wire logic [4:0] wunit = narrow_in_r ? mqps_pkg::UNIT_NARROW : mqps_pkg::UNIT_WIDE;
    wire logic [4:0] runit = narrow_out_r ? mqps_pkg::UNIT_NARROW : mqps_pkg::UNIT_WIDE;

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            pin_s1_r <= 5'h00;
            pin_s2_r <= 5'h00;
        end
        else
        begin
            pin_s1_r <= {IN_WIDTH_SEL_IN, OUT_WIDTH_SEL_IN, DEVICE_ID_IN};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Widths caught once after release, never again; all queues share them
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            cfg_cnt_r <= 2'h0;
            cfg_done_r <= 1'b0;
            narrow_in_r <= 1'b0;
            narrow_out_r <= 1'b0;
        end
        else if (!cfg_done_r)
        begin
            cfg_cnt_r <= cfg_cnt_r + 2'h1;
            if (cfg_cnt_r == mqps_pkg::CFG_SETTLE)
            begin
                cfg_done_r <= 1'b1;
                narrow_in_r <= pin_s2_r[4];
                narrow_out_r <= pin_s2_r[3];
            end
        end
    end

    // Register bus decode; one wait state, unmapped reads give zero
    wire logic wb_req = WB_CYC_IN && WB_STB_IN && !wb_ack_r;
    wire logic ctrl_wr = wb_req && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == mqps_pkg::CTRL_OFFS;
    wire logic [31:0] status_w = {15'h0000, rsrc_r.null_q, rsrc_r.q, wact_r.q, !out_v_r,
        cfg_done_r, narrow_out_r, narrow_in_r, q_ready, q_full};
    wire logic [31:0] wb_rdata = (WB_ADR_IN == mqps_pkg::CTRL_OFFS) ? {30'h0, ctrl_r} :
        (WB_ADR_IN == mqps_pkg::STATUS_OFFS) ? status_w : 32'h0000_0000;

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
            ctrl_r <= mqps_pkg::CTRL_RESET;
        end
        else
        begin
            wb_ack_r <= wb_req;
            wb_dat_r <= wb_req ? wb_rdata : 32'h0000_0000;
            if (ctrl_wr)
                ctrl_r <= WB_DAT_IN[1:0];
        end
    end

    // Write selection: queue bits only, no null meaning on this port
    wire logic wr_hit = WR_ADDR_IN[4:mqps_pkg::WR_DEV_LSB] == dev_id;
    wire logic wr_do = cfg_done_r && wact_r.hit && !WR_EN_N_IN && !q_full[wact_r.q]
        && !ctrl_r[mqps_pkg::CTRL_WBLOCK_BIT];

    // Status and data target both follow on the same edge, one edge after selection
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            wsel_r <= mqps_pkg::SEL_RESET;
            wact_r <= mqps_pkg::SEL_RESET;
            full_n_r <= 1'b1;
            full_oe_r <= 1'b0;
        end
        else
        begin
            if (WR_SEL_IN)
                wsel_r <= '{q: WR_ADDR_IN[1:mqps_pkg::WR_Q_LSB], null_q: 1'b0, hit: wr_hit};
            wact_r <= wsel_r;
            full_n_r <= !(wsel_r.hit && q_full[wsel_r.q]);
            full_oe_r <= wsel_r.hit;
        end
    end

    // Read selection; the source lags one edge so two old words still flow
    wire logic rd_hit = RD_ADDR_IN[5:mqps_pkg::RD_DEV_LSB] == dev_id;
    wire logic src_ok = cfg_done_r && rsrc_r.hit && !rsrc_r.null_q && q_ready[rsrc_r.q];
    wire logic advance = !RD_EN_N_IN || !out_v_r;
    wire logic load = src_ok && (!st_v_r || advance);
    wire logic [5:0] rd_idx0 = {rsrc_r.q, rp_w[rsrc_r.q]};
    wire logic [5:0] rd_idx1 = {rsrc_r.q, rp_w[rsrc_r.q] + 4'h1};
    wire logic [17:0] pop_word = narrow_out_r ? {9'h000, mem[rd_idx0]} :
        {mem[rd_idx1], mem[rd_idx0]};

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            rsel_r <= mqps_pkg::SEL_RESET;
            rsrc_r <= mqps_pkg::SEL_RESET;
        end
        else
        begin
            if (RD_SEL_IN)
                rsel_r <= '{q: RD_ADDR_IN[1:0], null_q: RD_ADDR_IN[mqps_pkg::RD_NULL_BIT],
                    hit: rd_hit};
            rsrc_r <= rsel_r;
        end
    end

    // Two-stage pipeline; a null or empty source just lets it drain
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            st_data_r <= 18'h00000;
            st_v_r <= 1'b0;
            out_data_r <= 18'h00000;
            out_v_r <= 1'b0;
        end
        else
        begin
            if (advance)
            begin
                if (st_v_r)
                    out_data_r <= st_data_r;
                out_v_r <= st_v_r;
            end
            if (load)
                st_data_r <= pop_word;
            if (load)
                st_v_r <= 1'b1;
            else if (advance)
                st_v_r <= 1'b0;
        end
    end

    // Storage holds 9-bit bytes; a wide write stores its low half first
    always_ff @(posedge REF_CLK_IN)
    begin
        if (wr_do)
        begin
            mem[{wact_r.q, wp_w[wact_r.q]}] <= WR_DATA_IN[8:0];
            if (!narrow_in_r)
                mem[{wact_r.q, wp_w[wact_r.q] + 4'h1}] <= WR_DATA_IN[17:9];
        end
    end

    // Per-queue byte counts; units follow the port that the flag serves
    for (genvar i = 0; i < N; i++)
    begin : g_q
        logic [3:0] wp_r;
        logic [3:0] rp_r;
        wire logic wr_i = wr_do && wact_r.q == 2'(i);
        wire logic rd_i = load && rsrc_r.q == 2'(i);
        assign wp_w[i] = wp_r;
        assign rp_w[i] = rp_r;
        assign cnt_nxt[i] = cnt_r[i] + (wr_i ? wunit : 5'h00) - (rd_i ? runit : 5'h00);
        assign q_full[i] = cnt_r[i] > mqps_pkg::Q_DEPTH - wunit;
        assign q_ready[i] = cnt_r[i] >= runit;

        always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
        begin
            if (!RSTN_IN)
            begin
                wp_r <= 4'h0;
                rp_r <= 4'h0;
                cnt_r[i] <= 5'h00;
            end
            else
            begin
                cnt_r[i] <= cnt_nxt[i];
                if (wr_i)
                    wp_r <= wp_r + wunit[3:0];
                if (rd_i)
                    rp_r <= rp_r + runit[3:0];
            end
        end
    end

    assign WB_DAT_OUT = wb_dat_r;
    assign WB_ACK_OUT = wb_ack_r;
    assign RD_DATA_OUT = out_data_r;
    assign WORD_VALID_N_OUT = !out_v_r;
    assign QUEUE_FULL_N_OUT = full_n_r;
    assign QUEUE_FULL_OE_OUT = full_oe_r;

    // Checks on the port behaviour
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    sequence s_null_sel;
        RD_SEL_IN && RD_ADDR_IN[mqps_pkg::RD_NULL_BIT];
    endsequence
    sequence s_drain;
        (!RD_EN_N_IN && !RD_SEL_IN) [*3];
    endsequence

    a_full_after_sel: assert property (WR_SEL_IN && wr_hit |=> ##1
        (QUEUE_FULL_N_OUT == !$past(q_full[wsel_r.q])))
        else $error("full flag not showing newly selected queue");
    a_oe_on_match: assert property (WR_SEL_IN && wr_hit |=> ##1 QUEUE_FULL_OE_OUT)
        else $error("full flag not driven for own device");
    a_oe_off_miss: assert property (WR_SEL_IN && !wr_hit |=> ##1 !QUEUE_FULL_OE_OUT)
        else $error("full flag driven for another device");
    a_no_full_wr: assert property (q_full[wact_r.q] |-> !wr_do)
        else $error("write accepted into full queue");
    a_full_units: assert property (wr_do |-> cnt_r[wact_r.q] + wunit <= mqps_pkg::Q_DEPTH)
        else $error("write overruns queue depth");
    a_null_drains: assert property (s_null_sel ##1 s_drain |=> !out_v_r)
        else $error("null queue did not empty the output");
    a_stale_hold: assert property ($fell(out_v_r) |-> $stable(RD_DATA_OUT))
        else $error("stale word changed when valid dropped");
    a_word_each: assert property (out_v_r && st_v_r && !RD_EN_N_IN |=> out_v_r)
        else $error("read bubble with word in pipeline");
    a_width_fixed: assert property ($past(cfg_done_r) |-> $stable(narrow_in_r))
        else $error("input width changed after configuration");
endmodule
